// >>> rtl/canria_ctrl.v
/*
 * can reset / init-mode / baud-search control: the lower half of the
 * control register, error counters, warning flag, bus-off recovery and
 * power-up sequencing, the baud-search loopback and the dual-port lock.
 * assumes a protocol core that reports frame ends, bit ticks and error
 * events on i_clk, and a cpu peripheral port with index and strobes.
 */
// Operation
// RULE1: soft reset waits frame end, clears registers
// RULE2: reset bit reads zero until engaged
// RULE3: dual-port memory untouched by soft reset
// RULE4: soft reset clears counters, sets init mode
// RULE5: reset held until software clears bit
// RULE6: eleven recessive bits before normal operation
// RULE7: reset off, init on: program at once
// RULE8: baud search feeds receiver bus AND transmit
// RULE9: baud search holds transmit pin recessive
// RULE10: baud search flags receive ok without store
// RULE11: software clears counters before each attempt
// RULE12: counter write zero gives error active
// RULE13: counter writes update flags, clear warning
// RULE14: status write clears last error code
// RULE15: leaving bus-off clears counters, sets init
// RULE16: warning at 96, or 128 when selected
// RULE17: init mode engages at frame end
// RULE18: counter writes only while init mode
// RULE19: init write one clears light sleep
// RULE20: low sixteen dual-port bytes locked outside init
// RULE21: bus-off recovery 128x11 then 11 bits
// RULE22: init locked while timing register zero
// RULE23: control bits 15..8 read zero
// RULE24: reset or init write exits light sleep
// RULE25: requests apply only at frame boundary
`timescale 1ns/100ps
`include "canria_map.vh"

module canria_ctrl (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_srst,
  // peripheral register port
  input  wire [3:0]  i_reg_idx,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [15:0] i_reg_wdata,
  output reg  [15:0] o_reg_rdata,
  // dual-port memory write gate
  input  wire        i_dp_wr,
  input  wire [7:0]  i_dp_addr,
  output reg         o_dp_wr_grant,
  // protocol core events
  input  wire        i_frame_done,
  input  wire        i_bus_idle,
  input  wire        i_bit_tick,
  input  wire        i_core_txd,
  input  wire        i_tx_err,
  input  wire        i_tx_ok,
  input  wire        i_rx_err,
  input  wire        i_rx_ok,
  input  wire        i_rx_stored,
  input  wire        i_err_valid,
  input  wire [2:0]  i_err_code,
  // bus pins
  input  wire        i_can_rx_pin,
  output reg         o_can_transmit_pin,
  // to the protocol core
  output reg         o_core_rxd,
  output reg         o_core_reset,
  output reg         o_core_run,
  output reg         o_error_passive,
  output reg         o_light_sleep,
  output reg  [15:0] o_bus_timing
);

  // ****************************************
  // sequencer states
  // ****************************************
  localparam [4:0] ST_IDLE  = 5'h01;  // bus activity disabled
  localparam [4:0] ST_SYNC  = 5'h02;  // power-up sequence
  localparam [4:0] ST_RUN   = 5'h04;  // normal operation
  localparam [4:0] ST_RECOV = 5'h08;  // bus-off recovery
  localparam [4:0] ST_RSYNC = 5'h10;  // power-up after recovery

  reg  [4:0] state;              // one-hot sequencer state
  reg  [3:0] bit_cnt;            // consecutive recessive bits
  reg  [7:0] seq_cnt;            // completed 11-bit groups
  reg        rx_s1;              // pin sync stage 1
  reg        rx_s2;              // pin sync stage 2
  reg        rx_s3;              // pin sync stage 3
  reg        rx_filt;            // accepted pin level
  reg        erie;               // error irq enable, stored only
  reg        stie;               // status irq enable, stored only
  reg        power_down_enable;  // stored only
  reg        baud_search_mode;
  reg        error_threshold_select;
  reg        rst_req;            // soft reset pending
  reg        can_soft_reset;     // soft reset engaged
  reg        init_req;           // init mode pending
  reg        init_mode;          // init mode engaged
  reg        bus_off_status;
  reg        error_warning_flag;
  reg        receive_ok_flag;
  reg        transmit_ok_flag;
  reg  [2:0] last_error_code;
  reg  [8:0] tec;                // transmit error counter
  reg  [7:0] rec;                // receive error counter
  reg  [7:0] bt0;                // bus timing 0
  reg  [7:0] bt1;                // bus timing 1
  reg  [8:0] next_tec;
  reg  [7:0] next_rec;

  wire       wr_ctrl  = i_reg_wr & (i_reg_idx == `CANRIA_IDX_CTRL);
  wire       wr_stat  = i_reg_wr & (i_reg_idx == `CANRIA_IDX_STAT);
  wire       wr_tec   = i_reg_wr & (i_reg_idx == `CANRIA_IDX_TEC);
  wire       wr_rec   = i_reg_wr & (i_reg_idx == `CANRIA_IDX_REC);
  wire       boundary = i_frame_done | i_bus_idle;  // see RULE25
  wire       timing_ok = (bt0 != `CANRIA_CLEAR) & (bt1 != `CANRIA_CLEAR);
  wire       running  = (state == ST_RUN);
  // the core sees the looped-back level, so count on that
  wire       rx_seen  = baud_search_mode ? (rx_filt & i_core_txd) : rx_filt;
  wire       rec_bit  = i_bit_tick & rx_seen;
  wire       dom_bit  = i_bit_tick & ~rx_seen;
  wire       pwr_done = rec_bit & (bit_cnt == `CANRIA_PWRUP_LAST);
  wire       recov_done = (state == ST_RSYNC) & pwr_done;
  wire [8:0] warn_lvl = error_threshold_select ? `CANRIA_WARN_HIGH : `CANRIA_WARN_LOW;

  // ****************************************
  // pin synchroniser
  // ****************************************

  // three flops; a level counts once stages two and three agree
  always @(posedge i_clk) begin
    if (i_srst) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_s3   <= 1'b1;
      rx_filt <= 1'b1;
    end else begin
      rx_s1 <= i_can_rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_filt <= rx_s3;
      end
    end
  end

  // ****************************************
  // error counter next values
  // ****************************************

  // counters only move while the core really runs; bus-off caps tec
  always @* begin
    next_tec = tec;
    next_rec = rec;
    if (running) begin
      if (i_tx_err) begin
        next_tec = (tec >= `CANRIA_BUSOFF - `CANRIA_TEC_STEP) ? `CANRIA_BUSOFF : tec + `CANRIA_TEC_STEP;
      end else if (i_tx_ok && tec != 9'h000) begin
        next_tec = tec - 9'h001;
      end
      if (i_rx_err && rec != 8'hFF) begin
        next_rec = rec + 8'h01;
      end else if (i_rx_ok && rec != 8'h00) begin
        next_rec = rec - 8'h01;
      end
    end
  end

  // ****************************************
  // control, status and counter registers
  // ****************************************

  // later assignments win: engage, bus-off and recovery override writes
  always @(posedge i_clk) begin
    if (i_srst) begin
      erie                   <= 1'b0;
      stie                   <= 1'b0;
      power_down_enable      <= 1'b0;
      o_light_sleep          <= 1'b0;
      baud_search_mode       <= 1'b0;
      error_threshold_select <= 1'b0;
      rst_req                <= 1'b0;
      can_soft_reset         <= 1'b1;
      init_req               <= 1'b0;
      init_mode              <= 1'b1;
      bus_off_status         <= 1'b0;
      error_warning_flag     <= 1'b0;
      o_error_passive        <= 1'b0;
      receive_ok_flag        <= 1'b0;
      transmit_ok_flag       <= 1'b0;
      last_error_code        <= 3'h0;
      tec                    <= 9'h000;
      rec                    <= 8'h00;
      bt0                    <= `CANRIA_CLEAR;
      bt1                    <= `CANRIA_CLEAR;
    end else begin
      tec <= next_tec;
      rec <= next_rec;
      // flags follow the counters, so any write updates them
      error_warning_flag <= (tec >= warn_lvl) | ({1'b0, rec} >= warn_lvl);  // see RULE16 see RULE13
      o_error_passive    <= (tec >= `CANRIA_PASSIVE) | ({1'b0, rec} >= `CANRIA_PASSIVE);  // see RULE12
      if (i_reg_wr && i_reg_idx == `CANRIA_IDX_BT0) begin
        bt0 <= i_reg_wdata[7:0];
      end
      if (i_reg_wr && i_reg_idx == `CANRIA_IDX_BT1) begin
        bt1 <= i_reg_wdata[7:0];
      end
      // counter writes only while init mode; zero to tec clears both
      if (wr_tec && init_mode) begin  // see RULE18
        tec <= {1'b0, i_reg_wdata[7:0]};
        if (i_reg_wdata[7:0] == `CANRIA_CLEAR) begin
          rec <= `CANRIA_CLEAR;  // see RULE12 see RULE11
        end
      end
      if (wr_rec && init_mode) begin  // see RULE18
        rec <= i_reg_wdata[7:0];
      end
      // status: set wins over a clearing write
      if (wr_stat) begin
        receive_ok_flag  <= i_reg_wdata[`CANRIA_STAT_RXOK];
        transmit_ok_flag <= i_reg_wdata[`CANRIA_STAT_TXOK];
        last_error_code  <= 3'h0;  // see RULE14
      end
      if (running && i_rx_ok && (baud_search_mode || i_rx_stored)) begin
        receive_ok_flag <= 1'b1;  // see RULE10
      end
      if (running && i_tx_ok) begin
        transmit_ok_flag <= 1'b1;
      end
      if (i_err_valid) begin
        last_error_code <= i_err_code;
      end
      // control register write; bits 15..8 are dropped
      if (wr_ctrl) begin  // see RULE23
        erie                   <= i_reg_wdata[`CANRIA_CTRL_ERIE];
        stie                   <= i_reg_wdata[`CANRIA_CTRL_STIE];
        power_down_enable      <= i_reg_wdata[`CANRIA_CTRL_PDE];
        baud_search_mode       <= i_reg_wdata[`CANRIA_CTRL_BAUD];
        error_threshold_select <= i_reg_wdata[`CANRIA_CTRL_ERROR_THRESHOLD_SELECT];
        // reset or init request forces light sleep off
        o_light_sleep <= i_reg_wdata[`CANRIA_CTRL_SIESTA] & ~i_reg_wdata[`CANRIA_CTRL_INIT]
                         & ~i_reg_wdata[`CANRIA_CTRL_RST];  // see RULE19 see RULE24
        if (i_reg_wdata[`CANRIA_CTRL_RST]) begin
          rst_req <= ~can_soft_reset;
        end else begin
          // a zero while nothing is engaged changes nothing running
          rst_req        <= 1'b0;  // see RULE5
          can_soft_reset <= 1'b0;
        end
        // bus-off locks out every write to the init bit
        if (!bus_off_status) begin  // see RULE21
          if (i_reg_wdata[`CANRIA_CTRL_INIT]) begin
            init_req <= ~init_mode;
          end else begin
            init_req <= 1'b0;
            if (timing_ok) begin
              init_mode <= 1'b0;  // see RULE22
            end
          end
        end
      end
      // init mode takes effect only between frames
      if (init_req && boundary && !(wr_ctrl && !i_reg_wdata[`CANRIA_CTRL_INIT])) begin
        init_mode <= 1'b1;  // see RULE17
        init_req  <= 1'b0;
      end
      // bus-off: drop init mode and start recovery
      if (tec >= `CANRIA_BUSOFF && !bus_off_status) begin
        bus_off_status <= 1'b1;  // see RULE21
        init_mode      <= 1'b0;
        init_req       <= 1'b0;
      end
      // recovery complete: counters cleared, init mode set
      if (recov_done) begin
        bus_off_status <= 1'b0;  // see RULE15
        init_mode      <= 1'b1;
        tec            <= 9'h000;
        rec            <= `CANRIA_CLEAR;
      end
      // soft reset engages at a frame boundary; dual-port memory is outside
      if (rst_req && boundary) begin  // see RULE1 see RULE3
        rst_req                <= 1'b0;
        can_soft_reset         <= 1'b1;  // see RULE2
        init_mode              <= 1'b1;  // see RULE4
        init_req               <= 1'b0;
        erie                   <= 1'b0;
        stie                   <= 1'b0;
        power_down_enable      <= 1'b0;
        o_light_sleep          <= 1'b0;
        baud_search_mode       <= 1'b0;
        error_threshold_select <= 1'b0;
        bus_off_status         <= 1'b0;
        error_warning_flag     <= 1'b0;
        receive_ok_flag        <= 1'b0;
        transmit_ok_flag       <= 1'b0;
        last_error_code        <= 3'h0;
        tec                    <= 9'h000;  // see RULE4
        rec                    <= `CANRIA_CLEAR;
        bt0                    <= `CANRIA_CLEAR;
        bt1                    <= `CANRIA_CLEAR;
      end
    end
  end

  // ****************************************
  // power-up and recovery sequencer
  // ****************************************

  // a dominant bit restarts the 11-bit count but keeps whole groups
  always @(posedge i_clk) begin
    if (i_srst) begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
      seq_cnt <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          bit_cnt <= 4'h0;
          seq_cnt <= 8'h00;
          if (bus_off_status) begin
            state <= ST_RECOV;
          end else if (!init_mode && !can_soft_reset) begin
            state <= ST_SYNC;  // see RULE6
          end
        end
        ST_SYNC, ST_RSYNC: begin
          if (!bus_off_status && (state == ST_RSYNC || init_mode || can_soft_reset)) begin
            state <= ST_IDLE;
          end else if (bus_off_status && state == ST_SYNC) begin
            state <= ST_RECOV;
          end else if (pwr_done) begin
            state   <= (state == ST_SYNC) ? ST_RUN : ST_IDLE;  // see RULE6 see RULE21
            bit_cnt <= 4'h0;
          end else if (rec_bit) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (dom_bit) begin
            bit_cnt <= 4'h0;
          end
        end
        ST_RUN: begin
          if (bus_off_status) begin
            state <= ST_RECOV;
          end else if (init_mode || can_soft_reset) begin
            state <= ST_IDLE;
          end
        end
        ST_RECOV: begin
          if (!bus_off_status) begin
            state <= ST_IDLE;
          end else if (pwr_done) begin
            bit_cnt <= 4'h0;
            seq_cnt <= seq_cnt + 8'h01;
            if (seq_cnt == `CANRIA_RECOV_LAST) begin
              state <= ST_RSYNC;  // see RULE21
            end
          end else if (rec_bit) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (dom_bit) begin
            bit_cnt <= 4'h0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pins, core strobes and read port
  // ****************************************

  // baud search: transmit kept off the bus, receiver sees the AND
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_can_transmit_pin <= 1'b1;
      o_core_rxd         <= 1'b1;
      o_core_reset       <= 1'b1;
      o_core_run         <= 1'b0;
      o_bus_timing       <= 16'h0000;
      o_dp_wr_grant      <= 1'b0;
      o_reg_rdata        <= 16'h0000;
    end else begin
      o_can_transmit_pin <= (baud_search_mode || !running) ? 1'b1 : i_core_txd;  // see RULE9
      o_core_rxd         <= rx_seen;  // see RULE8
      o_core_reset       <= can_soft_reset;  // see RULE5
      o_core_run         <= running & ~can_soft_reset;  // see RULE5
      o_bus_timing       <= {bt1, bt0};
      // outside init the control/status/mask bytes refuse writes
      o_dp_wr_grant <= i_dp_wr & ((i_dp_addr >= `CANRIA_DP_LOCKED) | init_mode);  // see RULE20 see RULE7
      if (i_reg_rd) begin
        case (i_reg_idx)
          `CANRIA_IDX_CTRL: o_reg_rdata <= {8'h00, erie, stie, power_down_enable, o_light_sleep,
                                             can_soft_reset, baud_search_mode, error_threshold_select,
                                             init_mode};  // see RULE23 see RULE2
          `CANRIA_IDX_STAT: o_reg_rdata <= {8'h00, bus_off_status, error_warning_flag, o_light_sleep,
                                             receive_ok_flag, transmit_ok_flag, last_error_code};
          `CANRIA_IDX_TEC:  o_reg_rdata <= {7'h00, tec};
          `CANRIA_IDX_REC:  o_reg_rdata <= {8'h00, rec};
          `CANRIA_IDX_BT0:  o_reg_rdata <= {8'h00, bt0};
          `CANRIA_IDX_BT1:  o_reg_rdata <= {8'h00, bt1};
          default:          o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule // canria_ctrl

// >>> rtl/canria_map.vh
/*
 * register indexes, field positions, reset values and sequence counts
 * for the can reset / init / autobaud control block.
 * assumes it is included by bare name from the rtl files.
 */
`ifndef CANRIA_MAP_VH
`define CANRIA_MAP_VH

// ****************************************
// peripheral register indexes
// ****************************************
`define CANRIA_IDX_CTRL    4'h0
`define CANRIA_IDX_STAT    4'h1
`define CANRIA_IDX_TEC     4'h2
`define CANRIA_IDX_REC     4'h3
`define CANRIA_IDX_BT0     4'h4
`define CANRIA_IDX_BT1     4'h5

// ****************************************
// control register field positions
// ****************************************
`define CANRIA_CTRL_INIT   0
`define CANRIA_CTRL_ERROR_THRESHOLD_SELECT   1
`define CANRIA_CTRL_BAUD   2
`define CANRIA_CTRL_RST    3
`define CANRIA_CTRL_SIESTA 4
`define CANRIA_CTRL_PDE    5
`define CANRIA_CTRL_STIE   6
`define CANRIA_CTRL_ERIE   7

// ****************************************
// status register field positions
// ****************************************
`define CANRIA_STAT_RXOK   4
`define CANRIA_STAT_TXOK   3

// ****************************************
// reset values and thresholds
// ****************************************
`define CANRIA_CTRL_RESET  8'h09
`define CANRIA_CLEAR       8'h00
`define CANRIA_WARN_LOW    9'h060
`define CANRIA_WARN_HIGH   9'h080
`define CANRIA_PASSIVE     9'h080
`define CANRIA_BUSOFF      9'h100
`define CANRIA_TEC_STEP    9'h008
`define CANRIA_DP_LOCKED   8'h10

// ****************************************
// sequence counts, last bit of a group and last 11-bit group
// ****************************************
`define CANRIA_PWRUP_LAST  4'hA
`define CANRIA_RECOV_LAST  8'h7F

`endif

// >>> testbench/canria_bus_node.sv
/* model of the other bus nodes: bit-time ticks and a wired-and bus.
   assumes pin level 1 is recessive and the bus idles recessive. */
`timescale 1ns/100ps
module canria_bus_node #(
  parameter int TICK_DIV = 4 // clocks per bit time, short to keep runs brief
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_hold_dominant, // bench asks for dominant bits
  input  wire logic i_dut_pin,
  output logic      o_bit_tick,
  output logic      o_bus_level
);
  logic [7:0] div; // bit time divider
  always @(posedge i_clk) begin
    if (i_srst || div == 8'(TICK_DIV - 1)) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
    o_bit_tick <= !i_srst && div == 8'(TICK_DIV - 1);
  end
  // any dominant driver wins, the termination pulls the rest recessive
  assign o_bus_level = i_dut_pin & !i_hold_dominant;
endmodule // canria_bus_node

// >>> testbench/canria_ctrl_asserts.sv
/* port checker for canria_ctrl.
   assumes a bind onto canria_ctrl, one clock, sync reset. */
`timescale 1ns/100ps
`include "canria_map.vh"
module canria_ctrl_asserts (
  input wire logic        i_clk, i_srst, i_reg_wr, i_reg_rd, i_dp_wr, i_bit_tick,
  input wire logic        i_can_rx_pin, o_can_transmit_pin, o_core_rxd, o_dp_wr_grant,
  input wire logic        o_core_reset, o_core_run, o_light_sleep,
  input wire logic [3:0]  i_reg_idx,
  input wire logic [7:0]  i_dp_addr,
  input wire logic [15:0] i_reg_wdata, o_reg_rdata, o_bus_timing
);
  // ****************************************
  // helper logic
  // ****************************************
  logic [3:0] rec_run; // recessive ticks in a row, saturates so it never wraps
  always @(posedge i_clk) begin
    if (i_srst || (i_bit_tick && !o_core_rxd)) begin
      rec_run <= 4'h0;
    end else if (i_bit_tick && rec_run != 4'hF) begin
      rec_run <= rec_run + 4'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence rx_low_s; !i_can_rx_pin [*8]; endsequence
  sequence dp_high_s; i_dp_wr && i_dp_addr >= `CANRIA_DP_LOCKED; endsequence
  sequence ctrl_rd_s; i_reg_rd && i_reg_idx == `CANRIA_IDX_CTRL; endsequence
  // ****************************************
  // assertions
  // ****************************************
  pin_idle_a: assert property (!o_core_run && !$past(o_core_run) |-> o_can_transmit_pin)
    else $error("transmit pin dominant while not running");
  dp_grant_a: assert property (dp_high_s |=> o_dp_wr_grant)
    else $error("upper dual-port write not granted");
  grant_cause_a: assert property (o_dp_wr_grant |-> $past(i_dp_wr))
    else $error("grant without request");
  loop_low_a: assert property (rx_low_s |-> !o_core_rxd)
    else $error("receiver not following low bus");
  run_excl_a: assert property (o_core_reset |-> !o_core_run)
    else $error("running while held in reset");
  power_up_a: assert property ($rose(o_core_run) |-> rec_run >= 4'hB)
    else $error("run started before eleven recessive bits");
  sleep_clr_a: assert property (i_reg_wr && i_reg_idx == `CANRIA_IDX_CTRL && i_reg_wdata[0] |-> ##2 !o_light_sleep)
    else $error("light sleep kept after init write");
  timing_clr_a: assert property ($rose(o_core_reset) |-> o_bus_timing == 16'h0000)
    else $error("timing not cleared by soft reset");
  resv_zero_a: assert property (ctrl_rd_s |=> o_reg_rdata[15:8] == 8'h00)
    else $error("reserved control bits read nonzero");
endmodule // canria_ctrl_asserts

// >>> testbench/tb.sv
/* self-checking bench for canria_ctrl.
   assumes canria_bus_node as the far side and a 100 ns clock. */
`timescale 1ns/100ps
module tb;
  logic        i_clk, i_srst, i_reg_wr, i_reg_rd, i_dp_wr, i_bus_idle, i_core_txd, dom, tick, bus;
  logic [3:0]  i_reg_idx, ev; // ev: frame done, tx err, rx ok, err valid
  logic [7:0]  i_dp_addr;
  logic [2:0]  i_err_code;
  logic [15:0] i_reg_wdata, o_reg_rdata, o_bus_timing;
  logic        o_dp_wr_grant, o_can_transmit_pin, o_core_rxd, o_core_reset, o_core_run;
  logic        o_error_passive, o_light_sleep;
  int          n_mismatch = 0, compares = 0, n_tick = 0, cyc = 0;
  canria_ctrl canria_ctrl_i (.*, .i_frame_done(ev[0]), .i_tx_err(ev[1]), .i_rx_ok(ev[2]),
    .i_err_valid(ev[3]), .i_tx_ok(1'b0), .i_rx_err(1'b0), .i_rx_stored(1'b0),
    .i_bit_tick(tick), .i_can_rx_pin(bus));
  canria_bus_node #(.TICK_DIV(4)) canria_bus_node_i (.i_clk(i_clk), .i_srst(i_srst),
    .i_hold_dominant(dom), .i_dut_pin(o_can_transmit_pin), .o_bit_tick(tick), .o_bus_level(bus));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // cycle ceiling cuts a hang short; bus-off recovery dominates the run
  always @(posedge i_clk) begin
    n_tick += int'(tick);
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_idx <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_reg_idx <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    rd(a);
    chk(nm, e, o_reg_rdata & m);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge i_clk);
    ev <= m;
    @(posedge i_clk);
    ev <= 4'h0;
    #1;
  endtask
  task automatic wait_run(input int t0);
    for (int k = 0; k < 400 && o_core_run !== 1'b1; k++) idle(1);
    chk("run", 16'h1, {15'h0, o_core_run});
    chk("ticks", 16'h1, {15'h0, n_tick - t0 >= 11});
  endtask
  task automatic dpw(input logic [7:0] a, input logic g);
    @(posedge i_clk);
    i_dp_addr <= a;
    i_dp_wr <= 1'b1;
    @(posedge i_clk);
    i_dp_wr <= 1'b0;
    #1 chk("grant", {15'h0, g}, {15'h0, o_dp_wr_grant});
  endtask
  task automatic s_reset;
    rdchk("ctrl", 4'h0, 16'hFFFF, 16'h0009);
    wr(4'h0, 16'hFF09);
    rdchk("ctrl_hi", 4'h0, 16'hFFFF, 16'h0009);
    rdchk("unmapped", 4'h7, 16'hFFFF, 16'h0000);
    rdchk("status", 4'h1, 16'hFFFF, 16'h0000);
  endtask
  task automatic s_init;
    int t;
    wr(4'h0, 16'h0001);
    rdchk("ctrl", 4'h0, 16'hFFFF, 16'h0001);
    wr(4'h2, 16'h0050);
    rdchk("tec", 4'h2, 16'h01FF, 16'h0050);
    wr(4'h0, 16'h0000);
    rdchk("ctrl_lock", 4'h0, 16'h0001, 16'h0001);
    wr(4'h4, 16'h0001);
    wr(4'h5, 16'h0002);
    t = n_tick;
    wr(4'h0, 16'h0000);
    rdchk("ctrl_off", 4'h0, 16'h0001, 16'h0000);
    chk("timing", 16'h0201, o_bus_timing);
    wait_run(t);
    wr(4'h2, 16'h0070);
    rdchk("tec_lock", 4'h2, 16'h01FF, 16'h0050);
    dpw(8'h0F, 1'b0);
    dpw(8'h10, 1'b1);
  endtask
  task automatic s_warn;
    wr(4'h0, 16'h0001);
    idle(3);
    rdchk("ctrl_init", 4'h0, 16'h0001, 16'h0001);
    wr(4'h2, 16'h005F);
    rdchk("warn95", 4'h1, 16'h0040, 16'h0000);
    wr(4'h2, 16'h0060);
    rdchk("warn96", 4'h1, 16'h0040, 16'h0040);
    wr(4'h0, 16'h0003);
    rdchk("warn_sel", 4'h1, 16'h0040, 16'h0000);
    wr(4'h2, 16'h0081);
    rdchk("warn129", 4'h1, 16'h0040, 16'h0040);
    chk("passive", 16'h1, {15'h0, o_error_passive});
    wr(4'h3, 16'h0010);
    wr(4'h2, 16'h0000);
    rdchk("warn0", 4'h1, 16'h00FF, 16'h0000);
    rdchk("rec0", 4'h3, 16'h01FF, 16'h0000);
    chk("passive0", 16'h0, {15'h0, o_error_passive});
    wr(4'h0, 16'h0012);
    idle(3);
    chk("sleep", 16'h1, {15'h0, o_light_sleep});
    wr(4'h0, 16'h0013);
    idle(3);
    chk("sleep_clr", 16'h0, {15'h0, o_light_sleep});
  endtask
  task automatic s_baud;
    int t;
    t = n_tick;
    wr(4'h0, 16'h0006);
    wait_run(t);
    @(posedge i_clk) i_core_txd <= 1'b0;
    idle(8);
    chk("txd_block", 16'h1, {15'h0, o_can_transmit_pin});
    chk("loop_tx", 16'h0, {15'h0, o_core_rxd});
    @(posedge i_clk) i_core_txd <= 1'b1;
    @(posedge i_clk) dom <= 1'b1;
    idle(8);
    chk("loop_bus", 16'h0, {15'h0, o_core_rxd});
    @(posedge i_clk) dom <= 1'b0;
    pulse(4'h4);
    rdchk("rx_ok", 4'h1, 16'h0010, 16'h0010);
    @(posedge i_clk) i_err_code <= 3'h3;
    pulse(4'h8);
    rdchk("err", 4'h1, 16'h0007, 16'h0003);
    wr(4'h1, 16'h0000);
    rdchk("err_clr", 4'h1, 16'h0017, 16'h0000);
    wr(4'h0, 16'h0002);
    pulse(4'h4);
    rdchk("rx_nostore", 4'h1, 16'h0010, 16'h0000);
    @(posedge i_clk) i_core_txd <= 1'b0;
    idle(8);
    chk("txd_run", 16'h0, {15'h0, o_can_transmit_pin});
    @(posedge i_clk) i_core_txd <= 1'b1;
    pulse(4'h2);
  endtask
  task automatic s_soft;
    @(posedge i_clk) i_bus_idle <= 1'b0;
    wr(4'h0, 16'h000A);
    idle(3);
    rdchk("rst_wait", 4'h0, 16'h0008, 16'h0000);
    pulse(4'h1);
    idle(3);
    rdchk("rst_on", 4'h0, 16'hFFFF, 16'h0009);
    rdchk("tec_rst", 4'h2, 16'h01FF, 16'h0000);
    rdchk("stat_rst", 4'h1, 16'hFFFF, 16'h0000);
    @(posedge i_clk) i_bus_idle <= 1'b1;
    idle(20);
    chk("core_rst", 16'h1, {15'h0, o_core_reset});
    chk("timing_rst", 16'h0, o_bus_timing);
    wr(4'h0, 16'h0001);
    wr(4'h0, 16'h0001);
    idle(3);
    chk("core_rst_off", 16'h0, {15'h0, o_core_reset});
    rdchk("ctrl_post", 4'h0, 16'hFFFF, 16'h0001);
  endtask
  task automatic s_busoff;
    int t;
    wr(4'h4, 16'h0001);
    wr(4'h5, 16'h0002);
    t = n_tick;
    wr(4'h0, 16'h0000);
    wait_run(t);
    repeat (32) pulse(4'h2);
    t = n_tick;
    rdchk("bus_off", 4'h1, 16'h0080, 16'h0080);
    wr(4'h0, 16'h0001);
    rdchk("init_off", 4'h0, 16'h0001, 16'h0000);
    for (int k = 0; k < 150 && o_reg_rdata[0] !== 1'b1; k++) begin
      idle(40);
      rd(4'h0);
    end
    chk("recov", 16'h1, {15'h0, n_tick - t >= 128 * 11 + 11});
    rdchk("bs_clr", 4'h1, 16'h00C0, 16'h0000);
    rdchk("tec_clr", 4'h2, 16'h01FF, 16'h0000);
    rdchk("rec_clr", 4'h3, 16'h01FF, 16'h0000);
  endtask
  initial begin
    i_srst = 1'b1;
    {i_reg_wr, i_reg_rd, i_dp_wr, dom, ev, i_reg_idx, i_dp_addr, i_err_code, i_reg_wdata} = '0;
    i_bus_idle = 1'b1;
    i_core_txd = 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    s_reset();
    s_init();
    s_warn();
    s_baud();
    s_soft();
    s_busoff();
    report_and_stop();
  end
endmodule // tb
bind canria_ctrl canria_ctrl_asserts canria_ctrl_asserts_i (.*);
